// ### src/apu_defs.svh
/*
 * Constants of the area protection unit: widths, operation codes,
 * configuration word layout, area default ranges and permissions.
 * Assumes inclusion by bare name from the package and design files.
 */
`ifndef APU_DEFS_SVH
`define APU_DEFS_SVH

// Access address width in bits
`define APU_ADDR_W      16
// Configuration data width in bits
`define APU_CFG_W       32
// Largest number of areas the source mask can name
`define APU_MAX_AREAS   8

// Operation codes, also the bit index into a permission nibble
`define APU_OP_READ     2'h0
`define APU_OP_WRITE    2'h1
`define APU_OP_DELETE   2'h2
`define APU_OP_EXEC     2'h3

// Configuration word selectors
`define APU_SEL_BASE    2'h0
`define APU_SEL_TOP     2'h1
`define APU_SEL_ATTR    2'h2

// Attribute word field positions
`define APU_ATTR_PU_LSB 0
`define APU_ATTR_PP_LSB 4
`define APU_ATTR_SM_LSB 8
`define APU_ATTR_LOCK   16

// Default ranges: area 0 ROM, area 1 RAM, area 2 flash, others empty
`define APU_ROM_BASE    16'h0000
`define APU_ROM_TOP     16'h3fff
`define APU_RAM_BASE    16'h4000
`define APU_RAM_TOP     16'h7fff
`define APU_FLASH_BASE  16'h8000
`define APU_FLASH_TOP   16'hffff
`define APU_EMPTY_BASE  16'hffff
`define APU_EMPTY_TOP   16'h0000

// Default permissions, bit order exec/delete/write/read
`define APU_ROM_PU      4'h9
`define APU_ROM_PP      4'h9
`define APU_RAM_PU      4'h3
`define APU_RAM_PP      4'h3
`define APU_FLASH_PU    4'h9
`define APU_FLASH_PP    4'hf
`define APU_EMPTY_P     4'h0
// Default source masks: code from any area may reach ROM, RAM and flash, none may reach empty areas
`define APU_SM_ALL      8'hff
`define APU_SM_NONE     8'h00

`endif

// ### src/apu_pkg.sv
/*
 * Types of the area protection unit: operation kind and area entry.
 * Assumes apu_defs.svh is on the include path.
 */
`default_nettype none
`include "apu_defs.svh"

package apu_pkg;

  // Kind of access requested by the core
  typedef enum logic [1:0] {
    APU_READ   = `APU_OP_READ,
    APU_WRITE  = `APU_OP_WRITE,
    APU_DELETE = `APU_OP_DELETE,
    APU_EXEC   = `APU_OP_EXEC
  } apu_op_e;

  // One protected area with its permission attributes
  typedef struct packed {
    logic [`APU_ADDR_W-1:0]    base;    // First address of the area
    logic [`APU_ADDR_W-1:0]    top;     // Last address of the area
    logic [3:0]                perm_u;  // Ops allowed in user mode
    logic [3:0]                perm_p;  // Ops allowed in privileged mode
    logic [`APU_MAX_AREAS-1:0] src;     // Areas code may run from
    logic                      lock;    // Entry frozen until reset
  } apu_area_s;

endpackage

`default_nettype wire

// ### src/apu_area_protection_unit.sv
/*
 * Area protection unit: checks each core access against area entries
 * and answers grant or deny one cycle later; privileged-only config port.
 * Assumes the memory acts only on grant_o and inputs are synchronous.
 */
// Behaviour
// R01: Check every read, write, delete, execute by mode
// R02: Only privileged writes change area attributes
// R03: Decide from source area, target area, operation
// R04: Decide before the access may complete
// R05: Evaluate per access; deny makes access inoperative
// R06: Attributes reset to fixed defaults, privileged override
// R07: Areas cover ROM, RAM and flash
// R08: Rules managed through the unit's control registers
// R09: Signal a violation on each denied access
`default_nettype none
`include "apu_defs.svh"

module apu_area_protection_unit
  import apu_pkg::*;
#(
  parameter int NUM_AREAS = 4,                 // Number of area entries
  parameter int IDX_W     = $clog2(NUM_AREAS)  // Entry index width
) (
  input  wire logic                   ref_clk_i,    // Core clock
  input  wire logic                   rst_i,        // Async reset, high
  input  wire logic                   req_valid_i,  // Access request
  input  wire apu_pkg::apu_op_e       req_op_i,     // Access kind
  input  wire logic [`APU_ADDR_W-1:0] req_addr_i,   // Target address
  input  wire logic [`APU_ADDR_W-1:0] req_pc_i,     // Executing code address
  input  wire logic                   req_priv_i,   // Requester privileged
  input  wire logic                   cfg_we_i,     // Config write strobe
  input  wire logic                   cfg_priv_i,   // Config writer privileged
  input  wire logic [IDX_W-1:0]       cfg_idx_i,    // Entry index
  input  wire logic [1:0]             cfg_sel_i,    // Word selector
  input  wire logic [`APU_CFG_W-1:0]  cfg_wdata_i,  // Config write data
  output logic                        grant_o,      // Access permitted
  output logic                        deny_o,       // Access blocked
  output logic [`APU_ADDR_W-1:0]      viol_addr_o,  // Last denied address
  output apu_pkg::apu_op_e            viol_op_o,    // Last denied op
  output logic                        cfg_ack_o,    // Config write taken
  output logic                        cfg_refused_o,// Config write ignored
  output logic [`APU_CFG_W-1:0]       cfg_rdata_o   // Config readback
);
  import apu_pkg::*;

  // Whole state of the unit
  typedef struct packed {
    apu_area_s [NUM_AREAS-1:0] areas;      // Area table
    logic                      grant;      // Grant pulse
    logic                      deny;       // Deny pulse
    logic [`APU_ADDR_W-1:0]    viol_addr;  // Captured denied address
    apu_op_e                   viol_op;    // Captured denied op
    logic                      cfg_ack;    // Config accept pulse
    logic                      cfg_ref;    // Config refuse pulse
    logic [`APU_CFG_W-1:0]     rdata;      // Readback word
  } apu_state_s;

  apu_state_s st;       // Registered state
  apu_state_s next_st;  // Next state

  // Default entry for an area index, constant for reset
  function automatic apu_area_s apu_default(input int i);
    apu_area_s a;
    a = '{base: `APU_EMPTY_BASE, top: `APU_EMPTY_TOP, perm_u: `APU_EMPTY_P,
          perm_p: `APU_EMPTY_P, src: `APU_SM_NONE, lock: 1'b0};
    case (i)
      0: begin
        a = '{base: `APU_ROM_BASE, top: `APU_ROM_TOP, perm_u: `APU_ROM_PU,
              perm_p: `APU_ROM_PP, src: `APU_SM_ALL, lock: 1'b0};
      end
      1: begin
        a = '{base: `APU_RAM_BASE, top: `APU_RAM_TOP, perm_u: `APU_RAM_PU,
              perm_p: `APU_RAM_PP, src: `APU_SM_ALL, lock: 1'b0};
      end
      2: begin
        a = '{base: `APU_FLASH_BASE, top: `APU_FLASH_TOP, perm_u: `APU_FLASH_PU,
              perm_p: `APU_FLASH_PP, src: `APU_SM_ALL, lock: 1'b0};
      end
      default: begin
        a = a;
      end
    endcase
    return a;
  endfunction

  // Reset image of the whole state
  function automatic apu_state_s apu_reset();
    apu_state_s s;
    s = '0;
    for (int i = 0; i < NUM_AREAS; i++) begin
      s.areas[i] = apu_default(i);
    end
    return s;
  endfunction

  logic [NUM_AREAS-1:0] t_hits;   // Target address inside area
  logic [NUM_AREAS-1:0] s_hits;   // Code address inside area

  // R07: per-area range match
  generate
    for (genvar g = 0; g < NUM_AREAS; g++) begin : g_match
      assign t_hits[g] = (req_addr_i >= st.areas[g].base) && (req_addr_i <= st.areas[g].top);
      assign s_hits[g] = (req_pc_i >= st.areas[g].base) && (req_pc_i <= st.areas[g].top);
    end
  endgenerate

  logic             t_hit;   // Target area found
  logic             s_hit;   // Source area found
  logic [IDX_W-1:0] t_idx;   // Lowest matching target area
  logic [IDX_W-1:0] s_idx;   // Lowest matching source area
  logic             allow;   // Access permitted
  logic             cfg_ok;  // Config write may land

  // Priority pick, lowest index wins on overlap
  always_comb begin
    t_hit = 1'b0;
    s_hit = 1'b0;
    t_idx = '0;
    s_idx = '0;
    for (int i = NUM_AREAS - 1; i >= 0; i--) begin
      if (t_hits[i]) begin
        t_hit = 1'b1;
        t_idx = IDX_W'(i);
      end
      if (s_hits[i]) begin
        s_hit = 1'b1;
        s_idx = IDX_W'(i);
      end
    end
  end

  // R01: R03: mode, source, target and op decide together
  always_comb begin
    allow = t_hit && s_hit && st.areas[t_idx].src[s_idx] &&
            (req_priv_i ? st.areas[t_idx].perm_p[req_op_i] : st.areas[t_idx].perm_u[req_op_i]);
  end

  // R02: only privileged, unlocked, valid writes land
  assign cfg_ok = cfg_priv_i && (32'(cfg_idx_i) < NUM_AREAS) &&
                  (cfg_sel_i != 2'h3) && !st.areas[cfg_idx_i].lock;

  // Next-state logic for decision, capture and configuration
  always_comb begin
    next_st = st;
    // R04: R05: answer each request before the memory may act
    next_st.grant   = req_valid_i && allow;
    next_st.deny    = req_valid_i && !allow;
    next_st.cfg_ack = cfg_we_i && cfg_ok;
    next_st.cfg_ref = cfg_we_i && !cfg_ok;
    // R09: record what was blocked
    if (req_valid_i && !allow) begin
      next_st.viol_addr = req_addr_i;
      next_st.viol_op   = req_op_i;
    end
    // R08: R06: privileged run-time override of defaults
    if (cfg_we_i && cfg_ok) begin
      case (cfg_sel_i)
        `APU_SEL_BASE: begin
          next_st.areas[cfg_idx_i].base = cfg_wdata_i[`APU_ADDR_W-1:0];
        end
        `APU_SEL_TOP: begin
          next_st.areas[cfg_idx_i].top = cfg_wdata_i[`APU_ADDR_W-1:0];
        end
        `APU_SEL_ATTR: begin
          next_st.areas[cfg_idx_i].perm_u = cfg_wdata_i[`APU_ATTR_PU_LSB +: 4];
          next_st.areas[cfg_idx_i].perm_p = cfg_wdata_i[`APU_ATTR_PP_LSB +: 4];
          next_st.areas[cfg_idx_i].src    = cfg_wdata_i[`APU_ATTR_SM_LSB +: `APU_MAX_AREAS];
          next_st.areas[cfg_idx_i].lock   = cfg_wdata_i[`APU_ATTR_LOCK];
        end
        default: begin
          next_st.areas = st.areas;
        end
      endcase
    end
    // R08: readback of selected word, privileged only
    next_st.rdata = '0;
    if (cfg_priv_i && (32'(cfg_idx_i) < NUM_AREAS)) begin
      case (cfg_sel_i)
        `APU_SEL_BASE: begin
          next_st.rdata = `APU_CFG_W'(st.areas[cfg_idx_i].base);
        end
        `APU_SEL_TOP: begin
          next_st.rdata = `APU_CFG_W'(st.areas[cfg_idx_i].top);
        end
        `APU_SEL_ATTR: begin
          next_st.rdata = `APU_CFG_W'({st.areas[cfg_idx_i].lock, st.areas[cfg_idx_i].src,
                                        st.areas[cfg_idx_i].perm_p, st.areas[cfg_idx_i].perm_u});
        end
        default: begin
          next_st.rdata = '0;
        end
      endcase
    end
  end

  // R06: state register, defaults on reset
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st <= apu_reset();
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from flip-flops
  assign grant_o       = st.grant;
  assign deny_o        = st.deny;
  assign viol_addr_o   = st.viol_addr;
  assign viol_op_o     = st.viol_op;
  assign cfg_ack_o     = st.cfg_ack;
  assign cfg_refused_o = st.cfg_ref;
  assign cfg_rdata_o   = st.rdata;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  a_user_cfg_refused: assert property (cfg_we_i && !cfg_priv_i |=> cfg_refused_o && !cfg_ack_o) // R02
    else $error("user config write not refused");
  a_user_cfg_stable: assert property (cfg_we_i && !cfg_priv_i |=> $stable(st.areas)) // R02
    else $error("user config write changed areas");
  a_req_answered: assert property (req_valid_i |=> grant_o != deny_o) // R05
    else $error("request not answered exactly once");
  a_idle_quiet: assert property (!req_valid_i |=> !grant_o && !deny_o) // R04
    else $error("answer without request");
  a_deny_capture: assert property (deny_o |-> viol_addr_o == $past(req_addr_i) && viol_op_o == $past(req_op_i)) // R09
    else $error("violation record wrong");
  a_user_perm: assert property (req_valid_i && !req_priv_i && t_hit &&
                                !st.areas[t_idx].perm_u[req_op_i] |=> deny_o) // R01
    else $error("user op granted without permission");
  a_src_mask: assert property (req_valid_i && s_hit && t_hit && !st.areas[t_idx].src[s_idx] |=> deny_o) // R03
    else $error("access from barred source granted");
  a_unmapped_deny: assert property (req_valid_i && !t_hit |=> deny_o && !grant_o) // R07
    else $error("unmapped access granted");
  a_unmapped_src: assert property (req_valid_i && !s_hit |=> deny_o && !grant_o) // R03
    else $error("access from unmapped code granted");

  c_grant: cover property (req_valid_i ##1 grant_o);
  c_deny_user: cover property (req_valid_i && !req_priv_i ##1 deny_o);
  c_cfg_then_grant: cover property (cfg_we_i && cfg_priv_i ##1 cfg_ack_o ##[1:4] grant_o);
  c_cfg_refused: cover property (cfg_we_i && !cfg_priv_i ##1 cfg_refused_o);
  c_unmapped: cover property (req_valid_i && !t_hit ##1 deny_o);

endmodule

`default_nettype wire

// ### verification/apu_core_model.sv
/*
 * Core model: issues one access per call and hands back the answer.
 * Assumes the unit answers grant or deny at the taking edge, read 5 ns after it.
 */
`default_nettype none
`include "apu_defs.svh"

module apu_core_model
  import apu_pkg::*;
(
  input  wire logic              clk_i,   // Core clock
  input  wire logic              grant_i, // Access permitted
  input  wire logic              deny_i,  // Access blocked
  output logic                   valid_o, // Request strobe
  output apu_pkg::apu_op_e       op_o,    // Access kind
  output logic [`APU_ADDR_W-1:0] addr_o,  // Target address
  output logic [`APU_ADDR_W-1:0] pc_o,    // Executing code address
  output logic                   priv_o   // Privileged mode
);
  timeunit 1ns;
  timeprecision 1ns;

  // Idle lines at time zero
  initial begin
    valid_o = 1'b0;
    op_o = APU_READ;
    addr_o = 16'h0000;
    pc_o = 16'h0000;
    priv_o = 1'b0;
  end

  // One request, held over its taking edge; released lines show the inverse
  task automatic access(input apu_op_e op, input logic [15:0] a, input logic [15:0] pc,
                        input logic pr, output logic [1:0] res);
    @(posedge clk_i);
    #5;
    valid_o = 1'b1;
    op_o = op;
    addr_o = a;
    pc_o = pc;
    priv_o = pr;
    @(posedge clk_i);
    #5;
    valid_o = 1'b0;
    op_o = apu_op_e'(~op);
    addr_o = ~a;
    pc_o = ~pc;
    priv_o = ~pr;
    res = {grant_i, deny_i};
  endtask
endmodule

`default_nettype wire

// ### verification/tb_apu_area_protection_unit.sv
/*
 * Bench of the area protection unit: defaults, config and lock, ranges, reset.
 * Assumes the core model and the design sources are compiled first.
 */
`default_nettype none
`include "apu_defs.svh"

module tb_apu_area_protection_unit import apu_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;

  logic        clk, rst, we, cpriv, valid, priv, grant, deny, ack, refused; // Bench nets
  logic [1:0]  idx, sel;          // Config entry and word
  logic [31:0] wdata, rdata;      // Config data
  logic [15:0] addr, pc, vaddr;   // Access and violation addresses
  apu_op_e     op, vop;           // Access and violation kinds
  int          miscompares, cmp_count; // Result counters
  logic [3:0]  def_pu [0:2] = '{`APU_ROM_PU, `APU_RAM_PU, `APU_FLASH_PU};     // Default user perms
  logic [3:0]  def_pp [0:2] = '{`APU_ROM_PP, `APU_RAM_PP, `APU_FLASH_PP};     // Default priv perms
  logic [15:0] def_top [0:2] = '{`APU_ROM_TOP, `APU_RAM_TOP, `APU_FLASH_TOP}; // Area last addresses

  // Clock of 50 ns
  always #25 clk = ~clk;

  apu_area_protection_unit u_apu_area_protection_unit (.ref_clk_i(clk), .rst_i(rst),
    .req_valid_i(valid), .req_op_i(op), .req_addr_i(addr), .req_pc_i(pc), .req_priv_i(priv),
    .cfg_we_i(we), .cfg_priv_i(cpriv), .cfg_idx_i(idx), .cfg_sel_i(sel), .cfg_wdata_i(wdata),
    .grant_o(grant), .deny_o(deny), .viol_addr_o(vaddr), .viol_op_o(vop), .cfg_ack_o(ack),
    .cfg_refused_o(refused), .cfg_rdata_o(rdata));

  apu_core_model u_apu_core_model (.clk_i(clk), .grant_i(grant), .deny_i(deny), .valid_o(valid),
    .op_o(op), .addr_o(addr), .pc_o(pc), .priv_o(priv));

  // Compare a grant/deny pair
  task automatic chk_dec(input logic [1:0] got, input logic [1:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Compare a data word
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One config write; exp is {ack, refused}
  task automatic cfg_wr(input logic pr, input logic [1:0] i, input logic [1:0] s,
                        input logic [31:0] d, input logic [1:0] exp);
    @(posedge clk);
    #5;
    {we, cpriv, idx, sel, wdata} = {1'b1, pr, i, s, d};
    @(posedge clk);
    #5;
    {we, cpriv, wdata} = {1'b0, 1'b0, ~d};
    chk_dec({ack, refused}, exp);
  endtask

  // One readback of a table word
  task automatic rd(input logic [1:0] i, input logic [1:0] s, output logic [31:0] got);
    @(posedge clk);
    #5;
    {cpriv, idx, sel} = {1'b1, i, s};
    @(posedge clk);
    #5;
    cpriv = 1'b0;
    got = rdata;
  endtask

  // Every op in both modes at the last address of each of the three default areas 0 to 2
  task automatic test_defaults();
    logic [1:0] res, exp;
    for (int ar = 0; ar < 3; ar++) begin
      for (int o = 0; o < 4; o++) begin
        for (int p = 0; p < 2; p++) begin
          exp = (p == 1 ? def_pp[ar][o] : def_pu[ar][o]) ? 2'b10 : 2'b01;
          u_apu_core_model.access(apu_op_e'(o), def_top[ar], 16'h0100, p[0], res);
          chk_dec(res, exp);
          if (exp == 2'b01) begin
            chk_val({14'h0000, vop, vaddr}, {14'h0000, o[1:0], def_top[ar]});
          end
        end
      end
    end
    $display("defaults test done");
  endtask

  // Privilege, source area, selector and lock on the config port
  task automatic test_config();
    logic [1:0]  res;
    logic [31:0] w;
    cfg_wr(1'b0, 2'h1, 2'h2, 32'h0000_0233, 2'b01);
    rd(2'h1, 2'h2, w);
    chk_val(w, 32'h0000_ff33);
    rd(2'h2, 2'h1, w);
    chk_val(w, 32'h0000_ffff);
    cfg_wr(1'b1, 2'h1, 2'h2, 32'h0000_0233, 2'b10);
    rd(2'h1, 2'h2, w);
    chk_val(w, 32'h0000_0233);
    u_apu_core_model.access(APU_READ, 16'h4010, 16'h0100, 1'b1, res);
    chk_dec(res, 2'b01);
    u_apu_core_model.access(APU_READ, 16'h4010, 16'h4100, 1'b1, res);
    chk_dec(res, 2'b10);
    cfg_wr(1'b1, 2'h1, 2'h3, 32'h0000_ff33, 2'b01);
    cfg_wr(1'b1, 2'h1, 2'h2, 32'h0001_0233, 2'b10);
    cfg_wr(1'b1, 2'h1, 2'h2, 32'h0000_ff33, 2'b01);
    rd(2'h1, 2'h2, w);
    chk_val(w, 32'h0001_0233);
    $display("config test done");
  endtask

  // Range words: shrink flash, unmapped target and code denied, then map area 3
  task automatic test_ranges();
    logic [1:0]  res;
    logic [31:0] w;
    cfg_wr(1'b1, 2'h2, 2'h1, 32'h0000_bfff, 2'b10);
    rd(2'h2, 2'h1, w);
    chk_val(w, 32'h0000_bfff);
    u_apu_core_model.access(APU_READ, 16'hc000, 16'h0100, 1'b1, res);
    chk_dec(res, 2'b01);
    chk_val({14'h0000, vop, vaddr}, 32'h0000_c000);
    u_apu_core_model.access(APU_EXEC, 16'h0200, 16'hc000, 1'b1, res);
    chk_dec(res, 2'b01);
    chk_val({14'h0000, vop, vaddr}, 32'h0003_0200);
    cfg_wr(1'b1, 2'h3, 2'h0, 32'h0000_c000, 2'b10);
    cfg_wr(1'b1, 2'h3, 2'h1, 32'h0000_ffff, 2'b10);
    cfg_wr(1'b1, 2'h3, 2'h2, 32'h0000_0f11, 2'b10);
    rd(2'h3, 2'h0, w);
    chk_val(w, 32'h0000_c000);
    u_apu_core_model.access(APU_READ, 16'hc000, 16'hc100, 1'b0, res);
    chk_dec(res, 2'b10);
    u_apu_core_model.access(APU_WRITE, 16'hc000, 16'hc100, 1'b0, res);
    chk_dec(res, 2'b01);
    $display("ranges test done");
  endtask

  // Reset in mid-run restores defaults and unlocks
  task automatic test_reset();
    logic [31:0] w;
    @(posedge clk);
    #5 rst = 1'b1;
    @(posedge clk);
    #5 rst = 1'b0;
    chk_val({14'h0000, vop, vaddr}, 32'h0000_0000);
    rd(2'h1, 2'h2, w);
    chk_val(w, 32'h0000_ff33);
    cfg_wr(1'b1, 2'h1, 2'h2, 32'h0000_ff13, 2'b10);
    $display("reset test done");
  endtask

  // Counts, verdict and end of run
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Hang guard
  initial begin
    repeat (5000) @(posedge clk);
    miscompares++;
    test_done();
  end

  // Main sequence
  initial begin
    {clk, rst, we, cpriv, idx, sel, wdata} = {1'b0, 1'b1, 1'b0, 1'b0, 2'h0, 2'h0, 32'h0};
    miscompares = 0;
    cmp_count = 0;
    repeat (12) @(posedge clk);
    #5 rst = 1'b0;
    test_defaults();
    test_config();
    test_ranges();
    test_reset();
    test_done();
  end
endmodule

`default_nettype wire
